/* File: inc/pss_consts.svh */
// constants of the supervisor register bank and serial port
// assumes a 100 MHz core clock; included by the rtl and the testbench
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
// ==========================================
// register addresses
`define PSS_ADDR_ID 7'h00
`define PSS_ADDR_CTRL 7'h01
`define PSS_ADDR_EVT 7'h0c
`define PSS_ADDR_SUPP 7'h0d
`define PSS_ADDR_KEY 7'h10
`define PSS_ADDR_PROT_LO 7'h11
`define PSS_ADDR_PROT_HI 7'h27
`define PSS_ADDR_LAST 7'h7f
`define PSS_PROT_COUNT 23
// ==========================================
// reset values and fields
`define PSS_CTRL_RST 8'h0d
`define PSS_SUPP_RST 8'hdf
`define PSS_CTRL_MIRROR 1
`define PSS_CTRL_LED 0
`define PSS_EVT_MIRROR 0
`define PSS_EVT_SIX 1
`define PSS_EVT_OV 2
`define PSS_EVT_LS 3
`define PSS_EVT_UV 4
`define PSS_KEY_FIRST 8'hba
`define PSS_KEY_SECOND 8'hbe
`define PSS_SYNC_RST 10'h100
// ==========================================
// timing
`define PSS_CLK_PERIOD_NS 10
`define PSS_EVT_REASSERT_US 32
`define PSS_EVT_REASSERT_CYC \
  ((`PSS_EVT_REASSERT_US * 1000) / `PSS_CLK_PERIOD_NS)
`endif

/* File: inc/pss_pkg.sv */
// types shared by the supervisor register bank
// assumes pss_consts.svh on the include path
package pss_pkg;
  typedef enum logic [1:0] {
    off_state,
    standby_state,
    mirror_supplies_only_state,
    full_power_state
  } pss_mode_t;
  // analog monitor levels, high means the condition is present
  typedef struct packed {
    logic supply_under;
    logic load_switch_low;
    logic led_overvoltage;
    logic six_volt_low;
    logic mirror_current_fail;
    logic mirror_out_of_reg;
  } pss_faults_t;
  typedef struct packed {
    logic mirror_rails;
    logic led_supply;
    logic led_driver;
    logic fast_shutdown;
    logic array_reset_out;
  } pss_power_t;
endpackage

/* File: rtl/pss_supervisor.sv */
// supervisor logic: serial register port, key lock, fault flags, modes
// assumes all pin inputs are asynchronous to clock_i; the serial
// clock must stay well below a quarter of the core clock
`include "pss_consts.svh"

// Function
// [R1] mirror regulator fault sets its flag, clears mirror enable, stops it
// [R2] clearing mirror enable also powers down the led driver
// [R3] host restarts by power request toggle, or re-enable when masked
// [R4] six volt rail low sets flag and holds led supply off, retrying
// [R5] led supply overvoltage sets flag, converter keeps running
// [R6] load switch collapse fast-shuts rails until power request toggles
// [R7] any event sets its flag and pulls the event pin low
// [R8] reading event flags releases the pin and clears the bits
// [R9] persisting fault re-pulls the pin within 32 us
// [R10] suppress bits only gate the pin, flags still set
// [R11] select high: input ignored, serial out released
// [R12] input sampled on serial clock rise, output on its fall
// [R13] first byte is command: msb write flag, low seven bits address
// [R14] address increments per data byte, wrapping 0x7f to 0x00
// [R15] 0x11 to 0x27 readable, writable only when unlocked
// [R16] unlock needs 0xba then 0xbe to key, nothing between
// [R17] unlock holds until a non-0xba key write or power cycle
// [R18] key register reads 0x00 locked, 0x01 unlocked
// [R19] power request low: off, defaults held, no serial, array reset low
// [R20] standby on power rise, mirror enable clear or fault
// [R21] active modes follow mirror enable and led supply on
// [R22] mirror enable zero after power rise, cleared by faults
// [R23] undervoltage raises event, clears mirror enable, goes standby
// [R24] bytes are eight bits, most significant bit first
module pss_supervisor
  import pss_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary identity value
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic power_request_i,
  input wire logic serial_clock_i,
  input wire logic serial_select_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic event_request_o,
  output logic event_request_oe_o,
  input wire pss_faults_t faults_i,
  output pss_power_t power_o,
  output pss_mode_t mode_o
);

  // ==========================================
  // input synchronisers
  logic [9:0] meta_reg;
  logic [9:0] sync_reg;
  logic sclk_prev_reg;
  wire [9:0] raw_in = {power_request_i, serial_select_n_i,
                       serial_clock_i, serial_in_i, faults_i};

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      meta_reg <= `PSS_SYNC_RST;
      sync_reg <= `PSS_SYNC_RST;
      sclk_prev_reg <= 1'b0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      sclk_prev_reg <= sync_reg[7];
    end
  end

  wire pss_faults_t flt = pss_faults_t'(sync_reg[5:0]);
  wire off = !sync_reg[9];
  wire sel = !sync_reg[8] && !off; // R11 R19
  wire sclk = sync_reg[7];
  wire din = sync_reg[6];
  wire sclk_rise = sclk && !sclk_prev_reg;
  wire sclk_fall = !sclk && sclk_prev_reg;

  // ==========================================
  // state
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_in_reg;
  logic cmd_seen_reg;
  logic wnr_reg;
  logic [6:0] ptr_reg;
  logic [7:0] tx_reg;
  logic out_reg;
  logic [7:0] ctrl_reg;
  logic [4:0] flags_reg;
  logic [7:0] supp_reg;
  logic unlocked_reg;
  logic key_stage_reg;
  logic mirror_hold_reg;
  logic ls_hold_reg;
  logic [7:0] prot_reg [`PSS_PROT_COUNT];
  pss_mode_t mode_reg;
  pss_power_t power_reg;

  function automatic logic is_prot(input logic [6:0] a);
    is_prot = a >= `PSS_ADDR_PROT_LO && a <= `PSS_ADDR_PROT_HI;
  endfunction

  function automatic logic [7:0] rd_data(input logic [6:0] a);
    case (a)
      `PSS_ADDR_ID: rd_data = CHIP_ID;
      `PSS_ADDR_CTRL: rd_data = ctrl_reg;
      `PSS_ADDR_EVT: rd_data = {3'h0, flags_reg};
      `PSS_ADDR_SUPP: rd_data = supp_reg;
      `PSS_ADDR_KEY: rd_data = {7'h00, unlocked_reg}; // R18
      default: rd_data = is_prot(a) ?
        prot_reg[5'(a - `PSS_ADDR_PROT_LO)] : 8'h00; // R15
    endcase
  endfunction

  // ==========================================
  // serial byte framing
  wire [7:0] rx_byte = {shift_in_reg, din}; // R24
  wire byte_done = sel && sclk_rise && bit_cnt_reg == 3'h7; // R12
  wire cmd_take = byte_done && !cmd_seen_reg; // R13
  wire data_done = byte_done && cmd_seen_reg;
  wire wr_stb = data_done && wnr_reg;
  wire [6:0] ptr_inc = ptr_reg + 7'h01; // R14
  wire rd_stb = (cmd_take && !rx_byte[7]) || (data_done && !wnr_reg);
  wire [6:0] rd_addr = cmd_take ? rx_byte[6:0] : ptr_inc;
  wire evt_read = rd_stb && rd_addr == `PSS_ADDR_EVT;

  // ==========================================
  // events and flags
  wire [4:0] evt = {flt.supply_under, flt.load_switch_low,
                    flt.led_overvoltage, flt.six_volt_low,
                    flt.mirror_out_of_reg || flt.mirror_current_fail};
  // set wins over the read clear, so a persisting fault stays visible
  wire [4:0] flags_next = (evt_read ? 5'h00 : flags_reg) | evt; // R7 R8 R9
  wire stop_fault = evt[`PSS_EVT_MIRROR] || evt[`PSS_EVT_UV] ||
                    evt[`PSS_EVT_LS] || ls_hold_reg; // R20 R23

  // ==========================================
  // control register and lock
  wire ctrl_wr = wr_stb && ptr_reg == `PSS_ADDR_CTRL;
  // after a mirror fault only a masked fault may be re-enabled by write
  wire mirror_block = mirror_hold_reg && !supp_reg[`PSS_EVT_MIRROR]; // R3
  wire [7:0] ctrl_wdata = {rx_byte[7:2],
                           rx_byte[`PSS_CTRL_MIRROR] && !mirror_block,
                           rx_byte[`PSS_CTRL_LED]};
  wire [7:0] ctrl_sel = ctrl_wr ? ctrl_wdata : ctrl_reg;
  wire [7:0] ctrl_next = stop_fault ?
    (ctrl_sel & ~(8'h01 << `PSS_CTRL_MIRROR)) : ctrl_sel; // R1 R22
  wire key_wr = wr_stb && ptr_reg == `PSS_ADDR_KEY;
  wire key_first = key_wr && rx_byte == `PSS_KEY_FIRST;
  wire key_stage_next = key_first ? 1'b1 :
    (wr_stb || rd_stb) ? 1'b0 : key_stage_reg; // R16
  wire unlocked_next = !key_wr ? unlocked_reg :
    key_first ? unlocked_reg :
    (rx_byte == `PSS_KEY_SECOND && key_stage_reg); // R16 R17
  wire prot_we = wr_stb && is_prot(ptr_reg) && unlocked_reg; // R15

  // ==========================================
  // operating mode
  wire mirror_en = ctrl_reg[`PSS_CTRL_MIRROR];
  wire led_en = ctrl_reg[`PSS_CTRL_LED];
  wire pss_mode_t mode_next = off ? off_state :
    (stop_fault || !mirror_en) ? standby_state : // R20
    led_en ? full_power_state : mirror_supplies_only_state; // R21
  wire pss_power_t power_next = '{
    mirror_rails: mode_next == mirror_supplies_only_state ||
                  mode_next == full_power_state,
    led_supply: mode_next == full_power_state &&
                !evt[`PSS_EVT_SIX], // R4 R5
    led_driver: mode_next == full_power_state, // R2
    fast_shutdown: ls_hold_reg || evt[`PSS_EVT_LS], // R6
    array_reset_out: !off // R19
  };

  // ==========================================
  // registers; all held at defaults while power request is low
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || off) begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 7'h00;
      cmd_seen_reg <= 1'b0;
      wnr_reg <= 1'b0;
      ptr_reg <= 7'h00;
    end else if (!sel) begin
      bit_cnt_reg <= 3'h0; // R11
      cmd_seen_reg <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_in_reg <= rx_byte[6:0];
      if (cmd_take) begin
        cmd_seen_reg <= 1'b1;
        wnr_reg <= rx_byte[7]; // R13
        ptr_reg <= rx_byte[6:0];
      end else if (data_done) begin
        ptr_reg <= ptr_inc; // R14
      end
    end
  end

  // transmit: loaded on the last rising edge, shifted on each fall
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || off) begin
      tx_reg <= 8'h00;
      out_reg <= 1'b0;
    end else if (rd_stb) begin
      tx_reg <= rd_data(rd_addr);
    end else if (sel && sclk_fall) begin
      out_reg <= tx_reg[7]; // R12 R24
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || off) begin
      ctrl_reg <= `PSS_CTRL_RST;
      flags_reg <= 5'h00;
      supp_reg <= `PSS_SUPP_RST;
      unlocked_reg <= 1'b0;
      key_stage_reg <= 1'b0;
      mirror_hold_reg <= 1'b0;
      ls_hold_reg <= 1'b0;
      mode_reg <= off_state;
      power_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      if (wr_stb && ptr_reg == `PSS_ADDR_SUPP)
        supp_reg <= rx_byte;
      unlocked_reg <= unlocked_next;
      key_stage_reg <= key_stage_next;
      mirror_hold_reg <= mirror_hold_reg || evt[`PSS_EVT_MIRROR];
      ls_hold_reg <= ls_hold_reg || evt[`PSS_EVT_LS]; // R6
      mode_reg <= mode_next;
      power_reg <= power_next;
    end
  end

  // protected scratch bytes
  for (genvar i = 0; i < `PSS_PROT_COUNT; i++) begin : g_prot
    always_ff @(posedge clock_i) begin
      if (!rst_n_i || off)
        prot_reg[i] <= 8'h00;
      else if (prot_we && ptr_reg == 7'(`PSS_ADDR_PROT_LO + i))
        prot_reg[i] <= rx_byte; // R15
    end
  end

  // ==========================================
  // outputs
  assign serial_out_o = out_reg;
  assign serial_out_oe_o = sel; // R11
  assign event_request_o = 1'b0;
  assign event_request_oe_o = |(flags_reg & ~supp_reg[4:0]); // R7 R10
  assign power_o = power_reg;
  assign mode_o = mode_reg;

  // ==========================================
  // checks
  localparam int EVT_MAX_CYC = `PSS_EVT_REASSERT_CYC;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // too long for a delay range, so the wait is counted instead
  logic [11:0] evt_wait_reg;
  wire evt_unsignalled = |(evt & ~supp_reg[4:0]) && !event_request_oe_o;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || off || !evt_unsignalled)
      evt_wait_reg <= 12'h000;
    else
      evt_wait_reg <= evt_wait_reg + 12'h001;
  end

  chk_mirror_fault_stop: assert property ( // R1
    !off && evt[`PSS_EVT_MIRROR] |=> !mirror_en &&
      flags_reg[`PSS_EVT_MIRROR] ##1 !power_o.mirror_rails)
    else $error("mirror fault did not stop regulator");
  chk_led_driver_follow: assert property ( // R2
    !mirror_en |=> !power_o.led_driver)
    else $error("led driver on without mirror enable");
  chk_six_volt_led: assert property ( // R4
    !off && evt[`PSS_EVT_SIX] |=> !power_o.led_supply &&
      flags_reg[`PSS_EVT_SIX])
    else $error("led supply on during six volt fault");
  chk_overvolt_keeps: assert property ( // R5
    !off && evt[`PSS_EVT_OV] && !stop_fault && mirror_en && led_en &&
      !evt[`PSS_EVT_SIX] |=> power_o.led_supply && flags_reg[`PSS_EVT_OV])
    else $error("overvoltage stopped led supply");
  chk_load_switch_hold: assert property ( // R6
    !off && evt[`PSS_EVT_LS] |=> power_o.fast_shutdown [*3])
    else $error("fast shutdown not held");
  chk_event_pin_low: assert property ( // R7
    !off && evt[`PSS_EVT_OV] && !supp_reg[`PSS_EVT_OV] && !wr_stb
      |=> event_request_oe_o && flags_reg[`PSS_EVT_OV])
    else $error("event pin not pulled low");
  chk_event_reassert: assert property ( // R9
    !off && evt_unsignalled |-> evt_wait_reg < 12'(EVT_MAX_CYC))
    else $error("persisting fault not re-signalled");

  chk_persist_pin_low: assert property ( // R9
    !off && evt_read && evt[`PSS_EVT_SIX] && !supp_reg[`PSS_EVT_SIX]
      |=> event_request_oe_o)
    else $error("pin released under standing fault");
  chk_suppress_flag: assert property ( // R10
    !off && evt[`PSS_EVT_MIRROR] && supp_reg[`PSS_EVT_MIRROR] |=>
      flags_reg[`PSS_EVT_MIRROR])
    else $error("masked event lost its flag");
  chk_key_readback: assert property ( // R18
    rd_stb && rd_addr == `PSS_ADDR_KEY |=> tx_reg == {7'h00,
      $past(unlocked_reg)})
    else $error("key readback wrong");
  chk_off_defaults: assert property ( // R19
    off |=> !power_o.array_reset_out && !mirror_en && !unlocked_reg)
    else $error("off mode not at defaults");

  chk_event_release: assert property ( // R8
    evt_read && evt == 5'h00 |=> flags_reg == 5'h00 && !event_request_oe_o)
    else $error("event read did not release pin");

  chk_addr_wrap: assert property ( // R14
    data_done && ptr_reg == `PSS_ADDR_LAST |=> ptr_reg == 7'h00)
    else $error("address did not wrap");

  chk_locked_write: assert property ( // R15
    wr_stb && is_prot(ptr_reg) && !unlocked_reg |=>
      prot_reg[5'($past(ptr_reg) - `PSS_ADDR_PROT_LO)] ==
      $past(prot_reg[5'(ptr_reg - `PSS_ADDR_PROT_LO)]))
    else $error("locked register was written");

  chk_unlock_key: assert property ( // R16
    !unlocked_reg ##1 unlocked_reg |-> $past(key_wr) &&
      $past(key_stage_reg) && $past(rx_byte) == `PSS_KEY_SECOND)
    else $error("unlocked without key sequence");

  chk_key_relock: assert property ( // R17
    key_wr && rx_byte != `PSS_KEY_FIRST && rx_byte != `PSS_KEY_SECOND
      |=> !unlocked_reg)
    else $error("other key byte did not lock");

  chk_key_first_keeps: assert property ( // R17
    key_wr && rx_byte == `PSS_KEY_FIRST |=> $stable(unlocked_reg))
    else $error("first key byte changed lock");

  chk_mode_active: assert property ( // R21
    !off && !stop_fault && mirror_en |=> power_o.mirror_rails &&
      mode_o == ($past(led_en) ? full_power_state :
      mirror_supplies_only_state))
    else $error("active mode does not follow enables");

  chk_fault_standby: assert property ( // R20 R23
    !off && evt[`PSS_EVT_UV] |=> mode_o == standby_state && !mirror_en)
    else $error("undervoltage did not force standby");

  chk_power_rise_mirror: assert property ( // R22
    off ##1 !off |-> !mirror_en)
    else $error("mirror enable set after power rise");
endmodule

/* File: tb/pss_host_model.sv */
// host model: serial master of the supervisor register port
// assumes clock_i is the core clock; pins move only at its rising edge
module pss_host_model #(
  parameter int HALF = 6
) (
  input wire logic clock_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // idle levels
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // ==========================================
  // one framed transfer of n bytes
  // serial clock rests low between frames, never free running
  task automatic frame(input logic [7:0] tx[4], input int n,
                       output logic [7:0] rx[4]);
    logic [7:0] b;
    b = 8'h00;
    @(posedge clock_i);
    sel_n_o <= 1'b0;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        sdi_o <= tx[k][i];
        // low phase alternates 6 and 7 cycles: 125 ns average period
        repeat (HALF + i % 2) @(posedge clock_i);
        sclk_o <= 1'b1;
        b[i] = sdo_i;
        repeat (HALF) @(posedge clock_i);
        sclk_o <= 1'b0;
      end
      rx[k] = b;
    end
    repeat (HALF) @(posedge clock_i);
    sel_n_o <= 1'b1;
    repeat (2 * HALF) @(posedge clock_i);
  endtask
endmodule

/* File: tb/tb.sv */
// testbench: register port, key lock, events and operating modes
// assumes the package, constants header and host model compiled first
`include "pss_consts.svh"
module tb import pss_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] TB_ID = 8'h3e; // arbitrary identity value
  logic clk, rst_n, pwr, sdo_d, sdo_oe, evt, evt_oe;
  logic sdo_last = 1'b0;
  logic sclk, sel_n, sdi;
  wire logic sdo_w;
  pss_faults_t flt;
  pss_power_t pw;
  pss_mode_t mode;
  int fails, n_tests;
  logic [7:0] v;
  logic [7:0] r[4];
  // ==========================================
  // released line floats: show the inverse of the last driven bit
  assign sdo_w = sdo_oe ? sdo_d : ~sdo_last;
  always @(posedge clk) if (sdo_oe) sdo_last <= sdo_d;
  pss_supervisor #(.CHIP_ID(TB_ID)) pss_supervisor_inst (.clock_i(clk),
    .rst_n_i(rst_n),
    .power_request_i(pwr), .serial_clock_i(sclk),
    .serial_select_n_i(sel_n), .serial_in_i(sdi),
    .serial_out_o(sdo_d), .serial_out_oe_o(sdo_oe),
    .event_request_o(evt), .event_request_oe_o(evt_oe),
    .faults_i(flt), .power_o(pw), .mode_o(mode));
  pss_host_model pss_host_model_inst (.clock_i(clk), .sdo_i(sdo_w),
    .sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mchk(input pss_mode_t e);
    chk({6'h00, mode}, {6'h00, e});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    pss_host_model_inst.frame('{{1'b1, a}, d, 8'h00, 8'h00}, 2, r);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    pss_host_model_inst.frame('{{1'b0, a}, 8'h00, 8'h00, 8'h00}, 2, r);
    chk(r[1], e);
  endtask
  task automatic cycle_power();
    pwr <= 1'b0;
    tick(6);
    pwr <= 1'b1;
    tick(8);
  endtask
  task automatic stop_test();
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    rst_n = 1'b0;
    pwr = 1'b0;
    flt = '0;
    fails = 0;
    n_tests = 0;
    tick(2);
    rst_n <= 1'b1;
    tick(4);
    mchk(off_state);
    chk(8'(pw.array_reset_out), 8'h00);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    pwr <= 1'b1;
    tick(8);
    mchk(standby_state);
    chk(8'(pw.array_reset_out), 8'h01);
    chk(8'(sdo_oe), 8'h00);
    rchk(`PSS_ADDR_CTRL, `PSS_CTRL_RST);
    rchk(`PSS_ADDR_SUPP, `PSS_SUPP_RST);
    rchk(`PSS_ADDR_KEY, 8'h00);
    wr(`PSS_ADDR_PROT_LO, 8'h5c);
    rchk(`PSS_ADDR_PROT_LO, 8'h00);
    wr(`PSS_ADDR_KEY, `PSS_KEY_FIRST);
    rchk(`PSS_ADDR_ID, TB_ID);
    wr(`PSS_ADDR_KEY, `PSS_KEY_SECOND);
    rchk(`PSS_ADDR_KEY, 8'h00);
    wr(`PSS_ADDR_KEY, `PSS_KEY_FIRST);
    wr(`PSS_ADDR_KEY, `PSS_KEY_SECOND);
    rchk(`PSS_ADDR_KEY, 8'h01);
    wr(`PSS_ADDR_KEY, `PSS_KEY_FIRST);
    rchk(`PSS_ADDR_KEY, 8'h01);
    pss_host_model_inst.frame('{8'ha6, 8'h3c, 8'hc3, 8'h00}, 3, r);
    rchk(7'h26, 8'h3c);
    rchk(7'h27, 8'hc3);
    pss_host_model_inst.frame('{8'h7f, 8'h00, 8'h00, 8'h00}, 3, r);
    chk(r[2], TB_ID);
    wr(`PSS_ADDR_KEY, 8'h00);
    wr(7'h26, 8'h11);
    rchk(7'h26, 8'h3c);
    wr(`PSS_ADDR_SUPP, 8'h00);
    wr(`PSS_ADDR_CTRL, 8'h0e);
    mchk(mirror_supplies_only_state);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    mchk(full_power_state);
    flt.led_overvoltage <= 1'b1;
    tick(6);
    chk(8'(evt_oe), 8'h01);
    chk(8'(evt), 8'h00);
    chk(8'(pw.led_supply), 8'h01);
    flt <= '0;
    tick(6);
    rchk(`PSS_ADDR_EVT, 8'h04);
    chk(8'(evt_oe), 8'h00);
    rchk(`PSS_ADDR_EVT, 8'h00);
    flt.six_volt_low <= 1'b1;
    tick(6);
    chk(8'(pw.led_supply), 8'h00);
    rchk(`PSS_ADDR_EVT, 8'h02);
    chk(8'(evt_oe), 8'h01);
    flt <= '0;
    tick(6);
    rchk(`PSS_ADDR_EVT, 8'h02);
    chk(8'(pw.led_supply), 8'h01);
    wr(`PSS_ADDR_SUPP, 8'h01);
    flt.mirror_current_fail <= 1'b1;
    tick(6);
    chk(8'(evt_oe), 8'h00);
    mchk(standby_state);
    chk({6'h00, pw.mirror_rails, pw.led_driver}, 8'h00);
    flt <= '0;
    rchk(`PSS_ADDR_EVT, 8'h01);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    mchk(full_power_state);
    wr(`PSS_ADDR_SUPP, 8'h00);
    flt.mirror_out_of_reg <= 1'b1;
    tick(6);
    flt <= '0;
    rchk(`PSS_ADDR_CTRL, 8'h0d);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    mchk(standby_state);
    cycle_power();
    mchk(standby_state);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    mchk(full_power_state);
    flt.load_switch_low <= 1'b1;
    tick(6);
    flt <= '0;
    chk(8'(pw.fast_shutdown), 8'h01);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    mchk(standby_state);
    rchk(`PSS_ADDR_EVT, 8'h08);
    cycle_power();
    chk(8'(pw.fast_shutdown), 8'h00);
    wr(`PSS_ADDR_CTRL, 8'h0f);
    flt.supply_under <= 1'b1;
    tick(6);
    flt <= '0;
    mchk(standby_state);
    rchk(`PSS_ADDR_CTRL, 8'h0d);
    rchk(`PSS_ADDR_EVT, 8'h10);
    stop_test();
  end
  initial begin
    #500000;
    fails++;
    stop_test();
  end
endmodule
